/* File: sbcp_pkg.sv */
// Shared constants, types and timing for the SBC pin and serial control block
package sbcp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;         // 40 MHz core clock
  localparam int SENSE_ON_US = 50;           // Cyclic-sense drive window
  localparam int SENSE_ON_CYC =
    (SENSE_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_PERIOD_MS = 10;         // Cyclic-sense repeat period
  localparam int CYC_PERIOD_CYC_DEF =
    CYC_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WD_DEFAULT_MS = 150;        // Internal watchdog period
  localparam int WD_DEFAULT_CYC_DEF =
    WD_DEFAULT_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_BITS = 4'h8;  // Only valid frame length
  localparam int CMD_MSB = 7;                // Command field
  localparam int CMD_LSB = 5;
  localparam logic [2:0] CMD_HS = 3'h1;      // High switch control
  localparam logic [2:0] CMD_LS = 3'h2;      // Low switch control
  localparam logic [2:0] CMD_MUX = 3'h3;     // Analog mux source
  localparam logic [2:0] CMD_GAIN = 3'h4;    // Current amp gain
  localparam logic [2:0] CMD_CYC = 3'h5;     // Cyclic-sense setup
  localparam logic [2:0] CMD_STAT = 3'h6;    // Status read and acknowledge

  // ----------------------------------------------------------------
  // Status byte layout: {events[2:0], wake, multipurpose inputs[3:0]}
  // ----------------------------------------------------------------
  localparam int ST_MP_LSB = 0;
  localparam int ST_WAKE = 4;
  localparam int ST_EVT_LSB = 5;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ----------------------------------------------------------------
  // Watchdog configuration pin states from the pin comparator
  // ----------------------------------------------------------------
  localparam logic [1:0] WDP_GROUND = 2'h0;
  localparam logic [1:0] WDP_RESISTOR = 2'h1;
  localparam logic [1:0] WDP_OPEN = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SBCP_MODE_RESET, SBCP_MODE_NORMAL_REQ, SBCP_MODE_NORMAL,
    SBCP_MODE_STOP, SBCP_MODE_SLEEP
  } sbcp_mode_e;

  typedef enum logic [2:0] {
    AMUX_BATT, AMUX_MP0, AMUX_MP1, AMUX_MP2, AMUX_MP3, AMUX_TEMP
  } sbcp_amux_e;
  localparam logic [2:0] AMUX_LAST = 3'h5;

  typedef struct packed {
    logic [1:0] hs_on;       // Static on, high switch b/a
    logic [1:0] hs_pwm;      // Follow pulse input, high switch b/a
    logic [1:0] ls_on;
    logic [1:0] ls_pwm;
    sbcp_amux_e amux;
    logic [1:0] gain;
    logic cyc_en;
    logic [1:0] cyc_hs;      // Which high switches power the sensing
  } sbcp_cfg_s;
  localparam sbcp_cfg_s CFG_RST = '0;

endpackage

/* File: sbcp_pin_ctrl.sv */
// Serial port, LIN pin, switch steering, reset, interrupt and wake logic
// ------------------------------------------------------------------
// Overview of operation
// - Serial output changes on serial clock rise
// - Serial input sampled on serial clock fall
// - Serial output released while select high
// - Select rise ends frame, latches data
// - Valid frame holds exactly eight bits
// - Select rise in stop mode wakes
// - Receive output low dominant, high recessive
// - Transmit low drives dominant, floating recessive
// - LIN transmit/receive only in normal mode
// - Pulse input steers switches in normal modes
// - Reset pin two-way; release gives request
// - Interrupt for events in normal modes and stop wake
// - Interrupt held until status read
// - Watchdog off grounded, resistor sets period
// - Open pin uses internal 150 ms period
// - Inputs readable, wake in low power
// - Cyclic sense wakes on sample change
// - Plain input change wakes stop/sleep
// - Mux-selected input loses digital and wake
// - Host picks analog mux source
// - Host sets current amp gain
// - Stop wake: request mode, interrupt mostly
// ------------------------------------------------------------------
`timescale 1ns/1ps

module sbcp_pin_ctrl #(
  parameter int CYC_PERIOD_CYC = sbcp_pkg::CYC_PERIOD_CYC_DEF,
  parameter int WD_DEFAULT_CYC = sbcp_pkg::WD_DEFAULT_CYC_DEF
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire sbcp_pkg::sbcp_mode_e MODE_I,
  input wire logic SPI_CLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  input wire logic LIN_TX_I,
  input wire logic LIN_BUS_I,
  output logic LIN_RX_O,
  output logic LIN_DOMINANT_O,
  input wire logic PULSE_CONTROL_INPUT_I,
  output logic [1:0] HIGH_SWITCH_O,
  output logic [1:0] LOW_SWITCH_O,
  input wire logic RESET_COND_I,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE_O,
  output logic HOST_RESET_O,
  output logic NORMAL_REQ_O,
  input wire logic [2:0] EVENT_I,
  output logic IRQ_N_O,
  output logic WAKE_O,
  input wire logic [1:0] WD_PIN_STATE_I,
  output logic WD_ENABLE_O,
  output logic WD_EXT_RES_O,
  output logic [22:0] WD_PERIOD_CYC_O,
  input wire logic [3:0] MULTIPURPOSE_INPUT_I,
  output logic [3:0] MP_DIVIDER_O,
  output sbcp_pkg::sbcp_amux_e ANALOG_MUX_SEL_O,
  output logic [1:0] CURRENT_AMP_GAIN_O
);
  import sbcp_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Switch drive: static on, or pulse input where steering is allowed
  function automatic logic [1:0] drive(input logic [1:0] on,
                                       input logic [1:0] pwm_en,
                                       input logic pwm, input logic ok);
    drive = on | (pwm_en & {2{pwm & ok}});
  endfunction

  // One-hot of the multipurpose input that the mux is tapping
  function automatic logic [3:0] mux_tap(input sbcp_amux_e sel);
    mux_tap = {sel == AMUX_MP3, sel == AMUX_MP2, sel == AMUX_MP1,
               sel == AMUX_MP0};
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers (two flops, first read only by second)
  // ----------------------------------------------------------------
  logic [10:0] sync1;          // First stage of every pin except data and pulse
  logic [10:0] sync2;          // Safe copies
  logic sclk_d;                // Delayed clock for edge detect
  logic cs_d;                  // Delayed select for edge detect
  logic rst_d;                 // Delayed reset pin for edge detect

  // Pins other than data and pulse are packed so a single pair of flops covers them
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      sync1 <= {2'h2, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      sync2 <= {2'h2, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      sync1 <= {WD_PIN_STATE_I, MULTIPURPOSE_INPUT_I, RST_PIN_I,
                LIN_BUS_I, LIN_TX_I, SPI_CS_N_I, SPI_CLK_I};
      sync2 <= sync1;
    end
  end

  wire sclk_s = sync2[0];
  wire cs_s = sync2[1];
  wire mosi_s;
  wire tx_s = sync2[2];
  wire bus_s = sync2[3];
  wire rstp_s = sync2[4];
  wire [3:0] mp_s = sync2[8:5];
  wire [1:0] wdp_s = sync2[10:9];

  // Data line gets its own pair; it only matters on clock falls
  logic mosi1;
  logic mosi2;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      mosi1 <= 1'b0;
      mosi2 <= 1'b0;
    end else begin
      mosi1 <= SPI_MOSI_I;
      mosi2 <= mosi1;
    end
  end
  assign mosi_s = mosi2;

  // Edge history
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      rst_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_s;
      rst_d <= rstp_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cs_fall = ~cs_s & cs_d;
  wire cs_rise = cs_s & ~cs_d;
  wire rst_rise = rstp_s & ~rst_d;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire mode_normal = (MODE_I == SBCP_MODE_NORMAL);
  wire mode_active = mode_normal | (MODE_I == SBCP_MODE_NORMAL_REQ);
  wire mode_stop = (MODE_I == SBCP_MODE_STOP);
  wire mode_low = mode_stop | (MODE_I == SBCP_MODE_SLEEP);

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_shift;        // Bits captured from the host
  logic [7:0] tx_shift;        // Status byte being returned
  logic [3:0] bit_cnt;         // Saturates above a legal frame
  logic [3:0] flags;           // {events[2:0], wake}
  sbcp_cfg_s cfg;              // Configuration written by the host

  wire [3:0] mp_tap = mux_tap(cfg.amux);
  wire [3:0] mp_digital = mp_s & ~mp_tap;
  wire [7:0] status_byte = {flags[3:1], flags[0], mp_digital};

  // Status is snapshotted at frame start and shifted MSB first
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      bit_cnt <= 4'h0;
      SPI_MISO_O <= 1'b0;
    end else if (cs_fall) begin
      tx_shift <= status_byte;
      SPI_MISO_O <= status_byte[7];
      bit_cnt <= 4'h0;
    end else if (!cs_s) begin
      if (sclk_fall) begin
        rx_shift <= {rx_shift[6:0], mosi_s};
        if (bit_cnt != 4'hF) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
      if (sclk_rise && bit_cnt != 4'h0) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
        SPI_MISO_O <= tx_shift[6];
      end
    end
  end

  // Output driver follows the synchronised select, so it lags by three
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      SPI_MISO_OE_O <= 1'b0;
    end else begin
      SPI_MISO_OE_O <= ~cs_s;
    end
  end

  // ----------------------------------------------------------------
  // Frame commit at select rise
  // ----------------------------------------------------------------
  wire frame_ok = cs_rise && (bit_cnt == FRAME_BITS);
  wire [2:0] cmd = rx_shift[CMD_MSB:CMD_LSB];
  wire [4:0] arg = rx_shift[4:0];
  wire status_ack = frame_ok && (cmd == CMD_STAT);

  // A short or long frame leaves everything untouched
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      cfg <= CFG_RST;
    end else if (frame_ok) begin
      if (cmd == CMD_HS) begin
        cfg.hs_on <= arg[1:0];
        cfg.hs_pwm <= arg[3:2];
      end else if (cmd == CMD_LS) begin
        cfg.ls_on <= arg[1:0];
        cfg.ls_pwm <= arg[3:2];
      end else if (cmd == CMD_MUX && arg[2:0] <= AMUX_LAST) begin
        cfg.amux <= sbcp_amux_e'(arg[2:0]);
      end else if (cmd == CMD_GAIN) begin
        cfg.gain <= arg[1:0];
      end else if (cmd == CMD_CYC) begin
        cfg.cyc_en <= arg[0];
        cfg.cyc_hs <= arg[2:1];
      end
    end
  end

  assign ANALOG_MUX_SEL_O = cfg.amux;
  assign CURRENT_AMP_GAIN_O = cfg.gain;
  assign MP_DIVIDER_O = mp_tap;

  // ----------------------------------------------------------------
  // Cyclic sensing
  // ----------------------------------------------------------------
  logic [22:0] cyc_cnt;        // Position inside the sense period
  logic [3:0] cyc_prev;        // Previous sampled input state
  logic cyc_valid;             // A first sample exists
  wire cyc_run = mode_low & cfg.cyc_en;
  wire sense_on = cyc_run && (cyc_cnt < 23'(SENSE_ON_CYC));
  wire sample_now = cyc_run && (cyc_cnt == 23'(SENSE_ON_CYC - 1));
  wire cyc_wake = sample_now && cyc_valid &&
                  |((mp_s ^ cyc_prev) & ~mp_tap);

  // Period counter restarts whenever sensing is not wanted
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I || !cyc_run) begin
      cyc_cnt <= 23'h00_0000;
      cyc_valid <= 1'b0;
      cyc_prev <= 4'h0;
    end else begin
      cyc_cnt <= (cyc_cnt == 23'(CYC_PERIOD_CYC - 1)) ? 23'h00_0000
                 : cyc_cnt + 23'h00_0001;
      if (sample_now) begin
        cyc_prev <= mp_s;
        cyc_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Switch and LIN drive
  // ----------------------------------------------------------------
  // Pulse pin pair; resets to the pulled-up level of the pin
  logic pwm1;
  logic pwm2;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      pwm1 <= 1'b1;
      pwm2 <= 1'b1;
    end else begin
      pwm1 <= PULSE_CONTROL_INPUT_I;
      pwm2 <= pwm1;
    end
  end

  // Pulse steering only counts in the two normal modes
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      HIGH_SWITCH_O <= 2'h0;
      LOW_SWITCH_O <= 2'h0;
      LIN_RX_O <= 1'b1;
      LIN_DOMINANT_O <= 1'b0;
    end else begin
      HIGH_SWITCH_O <= drive(cfg.hs_on, cfg.hs_pwm, pwm2, mode_active)
                       | (cfg.cyc_hs & {2{sense_on}});
      LOW_SWITCH_O <= drive(cfg.ls_on, cfg.ls_pwm, pwm2, mode_active);
      LIN_RX_O <= mode_normal ? bus_s : 1'b1;
      LIN_DOMINANT_O <= mode_normal & ~tx_s;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin, wake and interrupt
  // ----------------------------------------------------------------
  logic [3:0] mp_last;         // For plain change detection
  wire mp_change = mode_low && |((mp_s ^ mp_last) & ~mp_tap);
  logic [1:0] own_low;         // Our own pull-down still in the sync pair
  // Our own low takes two cycles to leave the sync flops after release;
  // without this mask it would be mistaken for a host reset
  wire host_rst = ~rstp_s & ~RESET_COND_I & ~RST_PIN_OE_O &
                  ~|own_low;
  wire wake_irq = mode_low & (mp_change | cyc_wake);
  wire wake_quiet = mode_stop & (cs_rise | (rst_d & ~rstp_s));
  wire [3:0] flag_set = {EVENT_I & {3{mode_active}},
                         wake_irq & mode_stop};
  wire [3:0] next_flags = (flags & ~{4{status_ack}}) | flag_set;

  // Set beats the acknowledge in the same cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      flags <= FLAGS_RST;
      mp_last <= 4'h0;
      own_low <= 2'h0;
      WAKE_O <= 1'b0;
      NORMAL_REQ_O <= 1'b0;
      HOST_RESET_O <= 1'b0;
      RST_PIN_OE_O <= 1'b0;
      IRQ_N_O <= 1'b1;
    end else begin
      flags <= next_flags;
      mp_last <= mp_s;
      own_low <= {own_low[0], RST_PIN_OE_O};
      WAKE_O <= wake_irq | wake_quiet;
      NORMAL_REQ_O <= rst_rise | (mode_stop & (wake_irq | wake_quiet));
      HOST_RESET_O <= host_rst;
      RST_PIN_OE_O <= RESET_COND_I;
      IRQ_N_O <= ~|next_flags;
    end
  end
  assign RST_PIN_O = 1'b0;                    // Open drain pull-down

  // ----------------------------------------------------------------
  // Watchdog configuration pin
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      WD_ENABLE_O <= 1'b0;
      WD_EXT_RES_O <= 1'b0;
      WD_PERIOD_CYC_O <= 23'h00_0000;
    end else begin
      WD_ENABLE_O <= (wdp_s != WDP_GROUND);
      WD_EXT_RES_O <= (wdp_s == WDP_RESISTOR);
      WD_PERIOD_CYC_O <= (wdp_s == WDP_OPEN) ? 23'(WD_DEFAULT_CYC)
                         : 23'h00_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_miso_hiz_idle: assert property (cs_s |=> !SPI_MISO_OE_O)
    else $error("MISO driven while select high");
  a_miso_rise_shift: assert property (!cs_s && !cs_fall && sclk_rise &&
    bit_cnt != 4'h0 |=> SPI_MISO_O == $past(tx_shift[6]))
    else $error("MISO did not shift on clock rise");
  a_mosi_fall_take: assert property (!cs_s && !cs_fall && sclk_fall
    |=> rx_shift[0] == $past(mosi_s))
    else $error("MOSI not captured on clock fall");
  a_frame_mux_latch: assert property (frame_ok && cmd == CMD_MUX &&
    arg[2:0] <= AMUX_LAST |=> cfg.amux == $past(arg[2:0]))
    else $error("Mux source not latched at frame end");
  a_bad_frame_kept: assert property (cs_rise && bit_cnt != FRAME_BITS
    |=> $stable(cfg))
    else $error("Wrong-length frame changed config");
  a_lin_off_idle: assert property (!mode_normal |=> !LIN_DOMINANT_O &&
    LIN_RX_O)
    else $error("LIN active outside normal mode");
  a_ls_no_pulse: assert property (!mode_active |=>
    LOW_SWITCH_O == $past(cfg.ls_on))
    else $error("Pulse steering outside normal modes");
  a_irq_held_low: assert property (!IRQ_N_O && !status_ack
    |=> !IRQ_N_O)
    else $error("Interrupt released without status read");
  a_cs_wake_quiet: assert property (mode_stop && cs_rise && !wake_irq
    |=> WAKE_O && flags[0] == $past(flags[0]))
    else $error("Select wake missing or raised interrupt");
  a_mux_no_digital: assert property (|(mp_tap & mp_digital) == 1'b0)
    else $error("Mux-tapped input still read digitally");

  c_valid_frame: cover property (frame_ok);
  c_status_ack: cover property (status_ack && !IRQ_N_O);
  c_cyclic_wake: cover property (cyc_wake);
  c_select_wake: cover property (mode_stop && cs_rise);
endmodule

/* File: sbcp_host_model.sv */
// Host model: serial master that drives the block's serial port
`timescale 1ns/1ps
module sbcp_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // Clock idles low and stands still between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame, MSB first; a count other than eight makes a bad frame
  task automatic frame(input logic [7:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i);
    #2 cs_n_o = 1'b0;
    mosi_o = tx[7];
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(posedge clk_i);
      #2 sclk_o = 1'b1;
      mosi_o = tx[7 - (i % 8)];
      repeat (4) @(posedge clk_i);
      #2 sclk_o = 1'b0;
      // Undriven line reads as the inverse, never a lucky match
      rx = {rx[6:0], miso_oe_i ? miso_i : ~rx[0]};
    end
    repeat (4) @(posedge clk_i);
    #2 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(posedge clk_i);
    #2;
  endtask
endmodule

/* File: sbcp_pin_ctrl_bench.sv */
// Self-checking bench for the pin and serial control block
`timescale 1ns/1ps
module sbcp_pin_ctrl_bench;
  import sbcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sbcp_mode_e mode = SBCP_MODE_NORMAL;
  sbcp_mode_e mlist [3] = '{SBCP_MODE_NORMAL_REQ, SBCP_MODE_NORMAL,
                            SBCP_MODE_STOP};
  logic sclk, cs_n, mosi, miso, miso_oe, rx_o, dom, rst_o, rst_oe;
  logic tx = 1'b1, bus = 1'b1, pwm = 1'b0, rst_cond = 1'b0;
  logic ext_low = 1'b0, host_rst, nreq, irq_n, wake, wd_en, wd_ext;
  logic [1:0] hs, ls, gain, wdp = 2'h2;
  logic [2:0] evt = 3'h0;
  logic [22:0] wd_per;
  logic [3:0] mp = 4'h0, div;
  sbcp_amux_e amux;
  logic [7:0] rd;
  int fail_count = 0, check_count = 0, wake_cnt = 0, nreq_cnt = 0;
  // Reset wire: weak pull-up unless either side pulls it down
  wire rst_pin = rst_oe ? rst_o : ~ext_low;

  always #12.5 clk = ~clk;
  // Count one-cycle pulses so no check can miss them
  always @(posedge clk) begin
    if (wake === 1'b1) wake_cnt++;
    if (nreq === 1'b1) nreq_cnt++;
  end

  sbcp_pin_ctrl #(.CYC_PERIOD_CYC(4000), .WD_DEFAULT_CYC(5000))
    sbcp_pin_ctrl_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .MODE_I(mode), .SPI_CLK_I(sclk), .SPI_CS_N_I(cs_n),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe),
    .LIN_TX_I(tx), .LIN_BUS_I(bus), .LIN_RX_O(rx_o),
    .LIN_DOMINANT_O(dom), .PULSE_CONTROL_INPUT_I(pwm),
    .HIGH_SWITCH_O(hs), .LOW_SWITCH_O(ls), .RESET_COND_I(rst_cond),
    .RST_PIN_I(rst_pin), .RST_PIN_O(rst_o), .RST_PIN_OE_O(rst_oe),
    .HOST_RESET_O(host_rst), .NORMAL_REQ_O(nreq), .EVENT_I(evt),
    .IRQ_N_O(irq_n), .WAKE_O(wake), .WD_PIN_STATE_I(wdp),
    .WD_ENABLE_O(wd_en), .WD_EXT_RES_O(wd_ext),
    .WD_PERIOD_CYC_O(wd_per), .MULTIPURPOSE_INPUT_I(mp),
    .MP_DIVIDER_O(div), .ANALOG_MUX_SEL_O(amux),
    .CURRENT_AMP_GAIN_O(gain));

  sbcp_host_model sbcp_host_model_inst (.clk_i(clk), .miso_i(miso),
    .miso_oe_i(miso_oe), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Wait whole cycles, then step off the edge before driving
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic xfer(input logic [7:0] b);
    sbcp_host_model_inst.frame(b, 8, rd);
  endtask
  // Static bits act always, pulse steering only in the normal modes
  function automatic logic [1:0] exp_sw(logic [1:0] on, pw, logic pin,
                                        sbcp_mode_e m);
    logic ok;
    ok = (m == SBCP_MODE_NORMAL) || (m == SBCP_MODE_NORMAL_REQ);
    return on | (pw & {2{pin & ok}});
  endfunction
  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", check_count,
             fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: a stuck sequence still reaches the verdict
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    logic [1:0] on, pw, g;
    logic [2:0] e;
    int w0, n0;
    void'($urandom(99536));
    tick(10);
    check("miso_oe", miso_oe, 1'b0);
    check("irq_n", irq_n, 1'b1);
    rst_n = 1'b1;
    tick(6);
    // LIN pins follow the bus only in normal mode
    foreach (mlist[k]) begin
      mode = mlist[k];
      repeat (6) begin
        tx = 1'($urandom);
        bus = 1'($urandom);
        tick(6);
        check("lin_dom", dom,
              mode == SBCP_MODE_NORMAL && !tx);
        check("lin_rx", rx_o,
              mode == SBCP_MODE_NORMAL ? bus : 1'b1);
      end
    end
    // Request mode with a dominant bus: receiver still parked high
    mode = SBCP_MODE_NORMAL_REQ;
    tx = 1'b0;
    bus = 1'b0;
    tick(6);
    check("lin_rx_busy", {dom, rx_o}, 2'h1);
    tx = 1'b1;
    bus = 1'b1;
    $display("Test lin done");
    // Switch steering: control written first, then pulse pin moves
    foreach (mlist[k]) begin
      mode = mlist[k];
      on = 2'($urandom);
      pw = 2'($urandom);
      xfer({CMD_HS, 1'b0, pw, on});
      xfer({CMD_LS, 1'b0, ~pw, ~on});
      for (int p = 0; p < 2; p++) begin
        pwm = p[0];
        tick(6);
        check("high_sw", hs, exp_sw(on, pw, pwm, mode));
        check("low_sw", ls, exp_sw(~on, ~pw, pwm, mode));
      end
    end
    mode = SBCP_MODE_NORMAL;
    xfer({CMD_HS, 5'h03});
    // Short and long frames must leave the setting alone
    sbcp_host_model_inst.frame({CMD_HS, 5'h00}, 7, rd);
    sbcp_host_model_inst.frame({CMD_HS, 5'h00}, 9, rd);
    check("bad_frame", hs, 2'h3);
    $display("Test frames done");
    // Every mux source and a random gain per step
    for (int s = 0; s < 6; s++) begin
      g = 2'($urandom);
      xfer({CMD_MUX, 2'h0, 3'(s)});
      xfer({CMD_GAIN, 3'h0, g});
      check("amux", amux, s);
      check("gain", gain, g);
      check("divider", div,
            (s >= 1 && s <= 4) ? 4'(1 << (s - 1)) : 4'h0);
    end
    xfer({CMD_MUX, 5'h06});
    check("amux_keep", amux, AMUX_LAST);
    $display("Test mux done");
    // Event raises interrupt; only the status read clears it
    xfer({CMD_MUX, 5'h00});
    mp = 4'($urandom);
    e = 3'($urandom_range(7, 1));
    evt = e;
    tick(1);
    evt = 3'h0;
    tick(5);
    check("irq_set", irq_n, 1'b0);
    xfer({CMD_HS, 5'h03});
    check("irq_hold", irq_n, 1'b0);
    xfer({CMD_STAT, 5'h00});
    check("status", rd, {e, 1'b0, mp});
    check("irq_clear", irq_n, 1'b1);
    $display("Test irq done");
    // Stop wakes: input change flags, select rise does not
    mode = SBCP_MODE_STOP;
    tick(6);
    w0 = wake_cnt;
    n0 = nreq_cnt;
    mp[0] = ~mp[0];
    tick(8);
    check("wake_in", wake_cnt - w0, 1);
    check("wake_req", nreq_cnt - n0, 1);
    check("wake_irq", irq_n, 1'b0);
    mode = SBCP_MODE_NORMAL;
    xfer({CMD_STAT, 5'h00});
    check("wake_flag", rd[ST_WAKE], 1'b1);
    mode = SBCP_MODE_STOP;
    w0 = wake_cnt;
    xfer(8'h00);
    check("wake_cs", wake_cnt - w0, 1);
    check("wake_cs_irq", irq_n, 1'b1);
    xfer({CMD_MUX, 5'h02});
    mode = SBCP_MODE_SLEEP;
    tick(6);
    w0 = wake_cnt;
    mp[1] = ~mp[1];
    tick(8);
    check("tapped_wake", wake_cnt - w0, 0);
    mp[2] = ~mp[2];
    tick(8);
    check("sleep_wake", wake_cnt - w0, 1);
    // Cyclic sense: switch a powers the window, samples are compared
    mode = SBCP_MODE_NORMAL;
    xfer({CMD_HS, 5'h00});
    xfer({CMD_CYC, 2'h0, 2'h1, 1'b1});
    mode = SBCP_MODE_SLEEP;
    tick(10);
    check("sense_on", hs, 2'h1);
    tick(2100);
    check("sense_off", hs, 2'h0);
    w0 = wake_cnt;
    mp[3] = ~mp[3];
    tick(8);
    check("cyc_plain", wake_cnt - w0, 1);
    tick(4000);
    check("cyc_wake", wake_cnt - w0, 2);
    mode = SBCP_MODE_NORMAL;
    $display("Test wake done");
    // Reset pin: device pull-down, then host-side low
    n0 = nreq_cnt;
    rst_cond = 1'b1;
    tick(3);
    check("rst_drive", {rst_oe, rst_o, host_rst}, 3'h4);
    rst_cond = 1'b0;
    tick(2);
    // Our own release must not read back as a host reset
    check("host_quiet", host_rst, 1'b0);
    tick(6);
    ext_low = 1'b1;
    tick(6);
    check("host_reset", host_rst, 1'b1);
    ext_low = 1'b0;
    tick(8);
    check("release_req", nreq_cnt - n0, 2);
    $display("Test reset pin done");
    // Watchdog pin: ground, resistor, open
    for (int w = 0; w < 3; w++) begin
      wdp = 2'(w);
      tick(6);
      check("wd_en", wd_en, w != 0);
      check("wd_ext", wd_ext, w == 1);
      check("wd_per", wd_per, w == 2 ? 5000 : 0);
    end
    $display("Test watchdog done");
    end_sim();
  end
endmodule
